// file: rtl/ccg_clock_ctrl.sv
// Purpose: clock generation control with APB register access
// Assumes: oscillator and slow clocks arrive as one-cycle ticks on pclk
// Notes:   clock outputs are one-cycle tick pulses, used as enables
// Summary of operation
// - after reset the cpu runs from the 500 kHz RC divided by eight.
// - fast divider codes 00..11 give osc clock divided by 1, 2, 4, 8.
// - in PLL mode code 00 gives half the osc clock.
// - mode field picks RC500, crystal, PLL, external or 2 MHz RC.
// - low two mode bits are writable only while oscillator is off.
// - port output divider codes 00..11 divide osc clock by 1..8.
// - cpu source bit picks slow clock at 0, fast clock at 1.
// - oscillator off forces cpu source bit to 0, cpu on slow clock.
// - enable bit starts and stops the fast oscillator, reset 1.
// - doubler enable turns the 64 kHz doubled slow clock on or off.
// - read-only lock flag is 1 only while PLL is active and in window.
// - five clocks out: slow, doubled slow, fast, cpu and port output.
// - RC500 mode delivers osc clock after 128 counted pulses, 8192 on the first start after reset.
// - PLL and crystal modes deliver osc clock after 4096 pulses.
// - 2 MHz RC mode delivers osc clock after 2048 pulses.
// - slow clock reaches peripherals after 8192 stabilising pulses.
`timescale 1ns/1ps
module ccg_clock_ctrl #(
    parameter int ADDR_W      = 18,
    parameter int RESET_START = ccg_pkg::START_RESET,
    parameter int SLOW_COUNT  = ccg_pkg::SLOW_STAB
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [ADDR_W-1:0]      paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire ccg_pkg::ccg_osc_ticks_t osc_ticks,
    input  wire logic                   slow_tick,
    input  wire logic                   slow_x2_tick,
    input  wire logic                   pll_in_window,
    output ccg_pkg::ccg_clk_out_t       clk_out,
    output logic                        fast_osc_run,
    output logic                        irq
);
    // ----------------------------------------------------------------
    // registers and decode
    // ----------------------------------------------------------------
    logic [7:0]              freq_control_0;
    logic [6:0]              freq_control_1;
    logic                    pll_lock_flag;
    logic [ccg_pkg::IRQ_W-1:0] irq_status;
    logic [ccg_pkg::IRQ_W-1:0] irq_mask;
    logic [15:0]             idx;
    logic                    acc;
    logic                    wr_lo0;
    logic                    wr_fc1;
    logic [7:0]              fc1_data;
    logic [7:0]              next_fc0;
    logic [6:0]              next_fc1;
    logic [2:0]              osc_mode;
    logic                    fast_osc_enable;
    logic                    cpu_clk_source;
    logic                    slow_doubler_enable;
    assign idx = 16'(paddr[ADDR_W-1:2]);
    assign acc = psel & penable & pready;
    assign wr_lo0 = acc & pwrite & (idx == ccg_pkg::IDX_FREQ_CTRL_0)
                  & pstrb[0];
    // second byte lane at the first address reaches the second register
    assign wr_fc1 = acc & pwrite &
                    (((idx == ccg_pkg::IDX_FREQ_CTRL_0) & pstrb[1]) |
                     ((idx == ccg_pkg::IDX_FREQ_CTRL_1) & pstrb[0]));
    assign fc1_data = (idx == ccg_pkg::IDX_FREQ_CTRL_0) ?
                      pwdata[15:8] : pwdata[7:0];
    assign osc_mode = {freq_control_0[ccg_pkg::OSC_MODE_HI],
                       freq_control_0[ccg_pkg::OSC_MODE_LO+1 -: 2]};
    assign fast_osc_enable     = freq_control_1[ccg_pkg::OSC_EN_BIT];
    assign cpu_clk_source      = freq_control_1[ccg_pkg::CPU_SRC_BIT];
    assign slow_doubler_enable = freq_control_1[ccg_pkg::DOUBLER_BIT];
    always_comb begin
        next_fc0 = freq_control_0;
        next_fc1 = freq_control_1;
        if (wr_lo0) begin
            next_fc0 = pwdata[7:0];
            if (fast_osc_enable) begin
                next_fc0[ccg_pkg::OSC_MODE_LO+1 -: 2] =
                    freq_control_0[ccg_pkg::OSC_MODE_LO+1 -: 2];
            end
        end
        if (wr_fc1) begin
            next_fc1 = fc1_data[6:0];
        end
        if (!next_fc1[ccg_pkg::OSC_EN_BIT]) begin
            next_fc1[ccg_pkg::CPU_SRC_BIT] = 1'b0;
        end
    end
    // reset values leave cpu on RC500 divided by eight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_control_0 <= ccg_pkg::RST_FREQ_CTRL_0;
            freq_control_1 <= ccg_pkg::RST_FREQ_CTRL_1[6:0];
        end else begin
            freq_control_0 <= next_fc0;
            freq_control_1 <= next_fc1;
        end
    end
    // ----------------------------------------------------------------
    // apb answer: zero wait, data prepared in the setup cycle
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (idx == ccg_pkg::IDX_FREQ_CTRL_0) begin
                    prdata <= {16'h0000, pll_lock_flag, freq_control_1,
                               freq_control_0};
                end else if (idx == ccg_pkg::IDX_FREQ_CTRL_1) begin
                    prdata <= {24'h00_0000, pll_lock_flag, freq_control_1};
                end else if (idx == ccg_pkg::IDX_IRQ_STATUS) begin
                    prdata <= {29'h0, irq_status};
                end else if (idx == ccg_pkg::IDX_IRQ_MASK) begin
                    prdata <= {29'h0, irq_mask};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // oscillator start-up
    // ----------------------------------------------------------------
    ccg_pkg::ccg_osc_state_t  osc_state;
    logic                     osc_tick;
    logic [ccg_pkg::CNT_W-1:0] start_cnt;
    logic [ccg_pkg::CNT_W-1:0] start_limit;
    logic                     first_start;
    always_comb begin
        osc_tick    = osc_ticks.rc2m;
        start_limit = ccg_pkg::CNT_W'(ccg_pkg::START_RC2M);
        case (osc_mode)
            ccg_pkg::MODE_RC500: begin
                osc_tick    = osc_ticks.rc500;
                start_limit = ccg_pkg::CNT_W'(ccg_pkg::START_RC500);
            end
            ccg_pkg::MODE_XTAL: begin
                osc_tick    = osc_ticks.xtal;
                start_limit = ccg_pkg::CNT_W'(ccg_pkg::START_XTAL);
            end
            ccg_pkg::MODE_PLL: begin
                osc_tick    = osc_ticks.pll;
                start_limit = ccg_pkg::CNT_W'(ccg_pkg::START_PLL);
            end
            ccg_pkg::MODE_EXT: begin
                osc_tick    = osc_ticks.ext;
                start_limit = ccg_pkg::CNT_W'(ccg_pkg::START_XTAL);
            end
            default: ;
        endcase
        if (first_start) begin
            start_limit = ccg_pkg::CNT_W'(RESET_START);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_state   <= ccg_pkg::OSC_OFF;
            start_cnt   <= '0;
            first_start <= 1'b1;
        end else begin
            case (osc_state)
                ccg_pkg::OSC_OFF: begin
                    start_cnt <= '0;
                    if (fast_osc_enable) begin
                        osc_state <= ccg_pkg::OSC_WAIT;
                    end
                end
                ccg_pkg::OSC_WAIT: begin
                    if (!fast_osc_enable) begin
                        osc_state <= ccg_pkg::OSC_OFF;
                    end else if (osc_tick) begin
                        start_cnt <= start_cnt + 1'b1;
                        if (start_cnt == start_limit - 1'b1) begin
                            osc_state   <= ccg_pkg::OSC_RUN;
                            first_start <= 1'b0;
                        end
                    end
                end
                ccg_pkg::OSC_RUN: begin
                    if (!fast_osc_enable) begin
                        osc_state <= ccg_pkg::OSC_OFF;
                    end
                end
                default: osc_state <= ccg_pkg::OSC_OFF;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // dividers and clock ticks
    // ----------------------------------------------------------------
    logic [2:0]                div_cnt;
    logic [1:0]                fast_sel;
    logic                      osc_live;
    logic                      fast_hit;
    logic                      out_hit;
    logic                      slow_ok;
    logic [ccg_pkg::CNT_W-1:0] slow_cnt;
    // a tick passes when the low sel bits of the divider are all ones
    function automatic logic div_hit(input logic [2:0] cnt,
                                     input logic [1:0] sel);
        logic [2:0] mask;
        mask = 3'((4'h1 << sel) - 4'h1);
        return (cnt & mask) == mask;
    endfunction
    assign osc_live = (osc_state == ccg_pkg::OSC_RUN) & osc_tick;
    always_comb begin
        fast_sel = freq_control_0[ccg_pkg::CPU_DIV_LSB+1 -: 2];
        if (osc_mode == ccg_pkg::MODE_PLL && fast_sel == 2'b00) begin
            fast_sel = 2'b01;
        end
    end
    assign fast_hit = osc_live & div_hit(div_cnt, fast_sel);
    assign out_hit  = osc_live &
        div_hit(div_cnt, freq_control_0[ccg_pkg::OUT_DIV_LSB+1 -: 2]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 3'h0;
        end else if (osc_state != ccg_pkg::OSC_RUN) begin
            div_cnt <= 3'h0;
        end else if (osc_tick) begin
            div_cnt <= div_cnt + 3'h1;
        end
    end
    // slow clock held back until the crystal has settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt <= '0;
            slow_ok  <= 1'b0;
        end else if (!slow_ok && slow_tick) begin
            slow_cnt <= slow_cnt + 1'b1;
            if (slow_cnt == ccg_pkg::CNT_W'(SLOW_COUNT - 1)) begin
                slow_ok <= 1'b1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out      <= '0;
            fast_osc_run <= 1'b0;
        end else begin
            clk_out.slow_clk         <= slow_ok & slow_tick;
            clk_out.slow_clk_doubled <= slow_ok & slow_doubler_enable &
                                        slow_x2_tick;
            clk_out.fast_clk         <= fast_hit;
            clk_out.port_out_clk     <= out_hit;
            // cpu falls back to slow clock whenever the source bit is 0
            clk_out.cpu_clk <= cpu_clk_source ? fast_hit
                                              : (slow_ok & slow_tick);
            fast_osc_run <= osc_state == ccg_pkg::OSC_RUN;
        end
    end
    // ----------------------------------------------------------------
    // lock flag and interrupts
    // ----------------------------------------------------------------
    logic [ccg_pkg::IRQ_W-1:0] events;
    logic [ccg_pkg::IRQ_W-1:0] clr;
    logic                      next_lock;
    assign next_lock = pll_in_window & fast_osc_enable &
                       (osc_mode == ccg_pkg::MODE_PLL);
    assign events = {~slow_ok & slow_tick &
                     (slow_cnt == ccg_pkg::CNT_W'(SLOW_COUNT - 1)),
                     next_lock & ~pll_lock_flag,
                     (osc_state == ccg_pkg::OSC_RUN) & ~fast_osc_run};
    assign clr = (acc && pwrite && idx == ccg_pkg::IDX_IRQ_STATUS &&
                  pstrb[0]) ? pwdata[ccg_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_lock_flag <= 1'b0;
            irq_status    <= '0;
            irq_mask      <= '0;
            irq           <= 1'b0;
        end else begin
            pll_lock_flag <= next_lock;
            // a new event wins over a same-cycle clear
            irq_status <= (irq_status & ~clr) | events;
            if (acc && pwrite && idx == ccg_pkg::IDX_IRQ_MASK && pstrb[0]) begin
                irq_mask <= pwdata[ccg_pkg::IRQ_W-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_lock_needs_pll: assert property (
        pll_lock_flag |-> $past(fast_osc_enable &&
                                osc_mode == ccg_pkg::MODE_PLL))
        else $error("lock flag set outside pll mode");
    a_src_forced_low: assert property (
        !fast_osc_enable |-> !cpu_clk_source)
        else $error("cpu source set while oscillator off");
    a_mode_bits_held: assert property (
        (wr_lo0 && fast_osc_enable) |=>
            $stable(freq_control_0[ccg_pkg::OSC_MODE_LO+1 -: 2]))
        else $error("mode bits changed while oscillator on");
    a_fast_after_run: assert property (
        clk_out.fast_clk |-> $past(osc_state == ccg_pkg::OSC_RUN))
        else $error("fast tick before oscillator ready");
    a_start_count: assert property (
        $rose(osc_state == ccg_pkg::OSC_RUN) |->
            $past(start_cnt) == $past(start_limit) - 1'b1)
        else $error("oscillator ready at wrong count");
    a_pll_half_rate: assert property (
        (osc_live && osc_mode == ccg_pkg::MODE_PLL && !div_cnt[0])
            |=> !clk_out.fast_clk)
        else $error("pll fast clock not halved");
    a_slow_gated: assert property (
        clk_out.slow_clk |-> $past(slow_ok))
        else $error("slow clock before stabilisation");
    a_doubler_gate: assert property (
        clk_out.slow_clk_doubled |-> $past(slow_doubler_enable))
        else $error("doubled clock while disabled");
    a_cpu_slow_path: assert property (
        ($past(!cpu_clk_source) && clk_out.cpu_clk) |-> clk_out.slow_clk)
        else $error("cpu tick not from slow clock");
    c_osc_ready:  cover property ($rose(fast_osc_run));
    c_pll_locked: cover property ($rose(pll_lock_flag));
    c_irq_raised: cover property ($rose(irq));
    c_word_write: cover property (wr_lo0 && wr_fc1);
endmodule

// file: rtl/ccg_pkg.sv
// Purpose: constants and types for the clock generation control block
// Assumes: registers stand at index*4 on APB; oscillators arrive as ticks
// Notes:   one tick per oscillator period, synchronous to pclk
package ccg_pkg;
    // ----------------------------------------------------------------
    // register indexes (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_FREQ_CTRL_0 = 16'hF002;
    localparam logic [15:0] IDX_FREQ_CTRL_1 = 16'hF003;
    localparam logic [15:0] IDX_IRQ_STATUS  = 16'hF004;
    localparam logic [15:0] IDX_IRQ_MASK    = 16'hF005;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_FREQ_CTRL_0 = 8'h33;
    localparam logic [7:0] RST_FREQ_CTRL_1 = 8'h03;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CPU_DIV_LSB   = 0;
    localparam int OSC_MODE_LO   = 2;
    localparam int OUT_DIV_LSB   = 4;
    localparam int OSC_MODE_HI   = 6;
    localparam int CPU_SRC_BIT   = 0;
    localparam int OSC_EN_BIT    = 1;
    localparam int DOUBLER_BIT   = 2;
    localparam int PLL_LOCK_BIT  = 7;
    localparam int IRQ_FAST_RDY  = 0;
    localparam int IRQ_PLL_LOCK  = 1;
    localparam int IRQ_SLOW_RDY  = 2;
    localparam int IRQ_W         = 3;
    // ----------------------------------------------------------------
    // start-up counts, in oscillator ticks
    // ----------------------------------------------------------------
    localparam int START_RC500   = 128;
    localparam int START_XTAL    = 4096;
    localparam int START_PLL     = 4096;
    localparam int START_RC2M    = 2048;
    localparam int START_RESET   = 8192;
    localparam int SLOW_STAB     = 8192;
    localparam int CNT_W         = 14;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RC500 = 3'b000,
        MODE_XTAL  = 3'b001,
        MODE_PLL   = 3'b010,
        MODE_EXT   = 3'b011,
        MODE_RC2M  = 3'b100
    } ccg_mode_t;
    typedef enum logic [2:0] {
        OSC_OFF  = 3'b001,
        OSC_WAIT = 3'b010,
        OSC_RUN  = 3'b100
    } ccg_osc_state_t;
    typedef struct packed {
        logic rc500;
        logic rc2m;
        logic xtal;
        logic pll;
        logic ext;
    } ccg_osc_ticks_t;
    typedef struct packed {
        logic slow_clk;
        logic slow_clk_doubled;
        logic fast_clk;
        logic cpu_clk;
        logic port_out_clk;
    } ccg_clk_out_t;
endpackage

// file: bench/ccg_osc_model.sv
// Purpose: oscillator and slow crystal tick source for the clock control
// Assumes: every tick is a one-cycle pulse on pclk
// Notes:   periods shortened so start-up counts finish quickly
`timescale 1ns/1ps
module ccg_osc_model (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                lock_req,
    output ccg_pkg::ccg_osc_ticks_t  osc_ticks,
    output logic                     slow_tick,
    output logic                     slow_x2_tick,
    output logic                     pll_in_window
);
    logic [7:0] cnt;
    // ----------------------------------------------------------------
    // free running tick pattern
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    // rc500 period 4, pll period 2: start counts stay short
    assign osc_ticks.rc500 = (cnt[1:0] == 2'h3);
    assign osc_ticks.rc2m  = cnt[0];
    assign osc_ticks.xtal  = (cnt[2:0] == 3'h5);
    assign osc_ticks.pll   = cnt[0];
    assign osc_ticks.ext   = (cnt[2:0] == 3'h7);
    assign slow_tick       = (cnt[3:0] == 4'hF);
    assign slow_x2_tick    = (cnt[2:0] == 3'h3);
    // lock window reached only when the bench asks for it
    assign pll_in_window   = lock_req;
endmodule

// file: bench/ccg_clock_ctrl_tb.sv
// Purpose: self-checking bench for the clock generation control
// Assumes: zero wait apb slave; reset start and slow counts shortened to 16
// Notes:   clock outputs are ticks, so rates are measured as periods
`timescale 1ns/1ps
module ccg_clock_ctrl_tb;
    logic                    pclk = 1'b0;
    logic                    presetn = 1'b0;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [17:0]             paddr = 18'h00000;
    logic [31:0]             pwdata = 32'h00000000;
    logic [3:0]              pstrb = 4'h0;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    ccg_pkg::ccg_osc_ticks_t osc_ticks;
    logic                    slow_tick;
    logic                    slow_x2_tick;
    logic                    pll_in_window;
    ccg_pkg::ccg_clk_out_t   clk_out;
    logic                    fast_osc_run;
    logic                    irq;
    logic                    lock_req = 1'b0;
    logic [31:0]             rd;
    logic                    err;
    int                      p;
    int                      fail_count = 0;
    int                      comparisons = 0;

    always #10 pclk = ~pclk;

    ccg_clock_ctrl #(.RESET_START(16), .SLOW_COUNT(16)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_ticks(osc_ticks), .slow_tick(slow_tick),
        .slow_x2_tick(slow_x2_tick), .pll_in_window(pll_in_window),
        .clk_out(clk_out), .fast_osc_run(fast_osc_run), .irq(irq));

    ccg_osc_model partner (
        .pclk(pclk), .presetn(presetn), .lock_req(lock_req),
        .osc_ticks(osc_ticks), .slow_tick(slow_tick),
        .slow_x2_tick(slow_x2_tick), .pll_in_window(pll_in_window));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] idx,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // third interval is taken, so a divider change has settled
    task automatic period(input int b);
        for (int k = 0; k < 3; k++) begin
            p = 0;
            do begin
                @(posedge pclk);
                p++;
            end while (clk_out[b] !== 1'b1 && p < 20000);
            if (p >= 20000) begin
                fail_count++;
                summarize();
            end
        end
    endtask

    // ready n ticks of period t after enable; tick phase spans t cycles
    task automatic wait_run(input int t, input int n);
        p = 0;
        do begin
            @(posedge pclk);
            p++;
        end while (fast_osc_run !== 1'b1 && p < 40000);
        chk(p > t * n - t + 3 && p < t * n + 4, 1'b1);
        if (p >= 40000) summarize();
    endtask

    // mode change with oscillator and cpu source off first
    task automatic start(input logic [7:0] m, input int t, input int n);
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_1, 32'h0, 4'h1);
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_0, {24'h00_0000, m}, 4'h1);
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_1, 32'h3, 4'h1);
        wait_run(t, n);
        period(2);
        chk(p, t * 2);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, ccg_pkg::IDX_FREQ_CTRL_0, 32'h0, 4'h3);
        chk(rd, 32'h00000333);
        apb(1'b0, ccg_pkg::IDX_FREQ_CTRL_1, 32'h0, 4'h1);
        chk(rd & 32'hFF, 32'h03);
        period(1);
        chk(p, 32);
        period(4);
        chk(p, 16);
    endtask

    task automatic t_dividers();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_0, (c << 4) | (3 - c), 4'h1);
            period(2);
            chk(p, 4 << (3 - c));
            period(0);
            chk(p, 4 << c);
        end
    endtask

    task automatic t_doubler();
        int n;
        n = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge pclk);
            if (clk_out.slow_clk_doubled === 1'b1) n++;
        end
        chk(n, 0);
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_1, 32'h07, 4'h1);
        period(3);
        chk(p, 8);
    endtask

    task automatic t_pll();
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_1, 32'h01, 4'h1);
        apb(1'b0, ccg_pkg::IDX_FREQ_CTRL_1, 32'h0, 4'h1);
        chk(rd & 32'hFF, 32'h00);
        period(1);
        chk(p, 16);
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_0, 32'h38, 4'h1);
        apb(1'b0, ccg_pkg::IDX_FREQ_CTRL_0, 32'h0, 4'h1);
        chk(rd & 32'hFF, 32'h38);
        lock_req <= 1'b1;
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_1, 32'h03, 4'h1);
        wait_run(2, ccg_pkg::START_PLL);
        period(2);
        chk(p, 4);
        period(1);
        chk(p, 4);
        apb(1'b0, ccg_pkg::IDX_FREQ_CTRL_1, 32'h0, 4'h1);
        chk(rd & 32'hFF, 32'h83);
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_0, 32'h30, 4'h1);
        apb(1'b0, ccg_pkg::IDX_FREQ_CTRL_0, 32'h0, 4'h1);
        chk(rd & 32'hFF, 32'h38);
        lock_req <= 1'b0;
        apb(1'b1, ccg_pkg::IDX_FREQ_CTRL_0, 32'h43B8, 4'h3);
        apb(1'b0, ccg_pkg::IDX_FREQ_CTRL_0, 32'h0, 4'h3);
        chk(rd & 32'hFFFF, 32'h43B8);
        period(2);
        chk(p, 4);
    endtask

    task automatic t_err_irq();
        apb(1'b1, 16'hF00F, 32'hFF, 4'h1);
        chk(err, 1'b1);
        apb(1'b0, ccg_pkg::IDX_IRQ_STATUS, 32'h0, 4'h1);
        chk(rd & 32'h1, 32'h1);
        chk(irq, 1'b0);
        apb(1'b1, ccg_pkg::IDX_IRQ_MASK, 32'h1, 4'h1);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, ccg_pkg::IDX_IRQ_STATUS, 32'h7, 4'h1);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
    endtask

    // every oscillator mode except PLL; external reuses the crystal start count
    task automatic t_modes();
        start(8'h31, 4, ccg_pkg::START_RC500);
        start(8'h71, 2, ccg_pkg::START_RC2M);
        start(8'h35, 8, ccg_pkg::START_XTAL);
        start(8'h3D, 8, ccg_pkg::START_XTAL);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_dividers();
        t_doubler();
        t_pll();
        t_err_irq();
        t_modes();
        summarize();
    end
endmodule
